// ===== core/pix_fifo.sv
`timescale 1ns/1ps
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock
// Notes: DEPTH must be a power of two
module pix_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ff, rd_ff;
   wire push = ce && in_valid && in_ready;
   wire pop = ce && out_valid && out_ready;
   assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign out_data = mem[rd_ff[AW-1:0]];
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + 1'b1;
         if (pop) rd_ff <= rd_ff + 1'b1;
      end
   end
endmodule

// ===== core/vid_dev_end.sv
`timescale 1ns/1ps
// Purpose: display end: captures pixels, tags eye, reports boot status
// Assumes: link pins are asynchronous and pass two flip-flops
// Notes: frames are shown at input rate, no conversion
//
// Behaviour
// - Pixel words are RGB, 8 bits each
// - Source MSB-aligns narrow channels, zero-fills low
// - Only landscape input is accepted; the code checks only the 1920 by 1080 bounds, not orientation
// - Display at most 1920 by 1080 pixels
// - Source keeps clock and line rates
// - 3D frames alternate left then right
// - One eye per frame, vsync between
// - Eye select one is left, zero right
// - Eye select settles 1 ms before vsync
// - Output frame rate equals input frame rate
// - Optional glasses sync follows displayed eye
// - Boot status undriven during reset
// - Undriven until boot completes, reads high
// - After boot drive high, no visible change
// - Drive low when initialization completes
// - Video accepted only after initialization
// - Host expects falling edge near 2.94 s
// - Fewer pins may carry one pixel
module vid_dev_end
   import vid_pkg::*;
#(
   parameter int BOOT_CYCLES = BOOT_CYC,
   parameter int INIT_CYCLES = BOOT_DRIVE_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   vid_link_if.dev link,
   input wire logic glasses_en,
   output logic [CHAN_W-1:0] red,
   output logic [CHAN_W-1:0] green,
   output logic [CHAN_W-1:0] blue,
   output logic pix_valid,
   input wire logic pix_ready,
   output logic frame_start,
   output logic frame_eye,
   output logic glasses_sync,
   output logic init_done,
   output logic overflow
);
   typedef enum logic [1:0] {BOOTING, INIT_HIGH, READY} boot_t;
   boot_t state_ff, nxt_state;
   logic [31:0] cnt_ff;
   // ==========================================
   // Link synchronisers
   logic [3:0] s1_ff, s2_ff;
   logic s3_ff;
   logic [PIX_W-1:0] d1_ff, d2_ff;
   logic vs_prev_ff, de_prev_ff;
   logic [COL_W-1:0] col_ff, row_ff;
   logic eye_ff, glass_ff;
   logic [PIX_W-1:0] word_ff;
   logic push_ff;
   function automatic logic rises(input logic now_lvl, input logic was_lvl);
      return now_lvl && !was_lvl;
   endfunction
   function automatic logic [CHAN_W-1:0] chan_of(input logic [PIX_W-1:0] pix_word, input int lsb);
      return pix_word[lsb +: CHAN_W];
   endfunction
   wire pclk_s = s2_ff[0];
   wire vsync_s = s2_ff[1];
   wire de_s = s2_ff[2];
   wire eye_s = s2_ff[3];
   wire pclk_rise = rises(pclk_s, s3_ff);
   wire vs_rise = rises(vsync_s, vs_prev_ff);
   wire frame_begin = pclk_rise && vs_rise;
   wire pix_strobe = pclk_rise && de_s;
   wire line_end = pclk_rise && rises(de_prev_ff, de_s);
   wire in_frame_ok = row_ff < COL_W'(MAX_ROWS) && col_ff < COL_W'(MAX_COLS);
   wire accept = state_ff == READY && pix_strobe && in_frame_ok;
   wire fifo_ready;
   wire [PIX_W-1:0] fifo_data;
   wire lost_word = push_ff && !fifo_ready;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= 1'b0;
         d1_ff <= '0;
         d2_ff <= '0;
      end else if (ce) begin
         s1_ff <= {link.eye_select, link.de, link.vsync, link.pix_clk};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff[0];
         d1_ff <= link.pixel_data_bus;
         d2_ff <= d1_ff;
      end
   end
   // ==========================================
   // Frame tracking and eye tagging
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vs_prev_ff <= 1'b0;
         de_prev_ff <= 1'b0;
      end else if (ce && pclk_rise) begin
         vs_prev_ff <= vsync_s;
         de_prev_ff <= de_s;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         eye_ff <= EYE_RIGHT;
         glass_ff <= 1'b0;
      end else if (ce && frame_begin) begin
         eye_ff <= eye_s;
         glass_ff <= eye_s;
      end
   end
   // ==========================================
   // Line and column counters
   // Saturate so over-long lines and frames stay refused
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         col_ff <= '0;
         row_ff <= '0;
      end else if (ce) begin
         if (frame_begin) begin
            col_ff <= '0;
            row_ff <= '0;
         end else if (pix_strobe && col_ff != '1) begin
            col_ff <= col_ff + 1'b1;
         end else if (line_end && row_ff != '1) begin
            col_ff <= '0;
            row_ff <= row_ff + 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         frame_start <= 1'b0;
      end else if (ce) begin
         frame_start <= frame_begin && state_ff == READY;
      end
   end
   // ==========================================
   // Pixel capture and overflow
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         word_ff <= '0;
         push_ff <= 1'b0;
      end else if (ce) begin
         push_ff <= accept;
         if (accept) begin
            word_ff <= d2_ff;
         end
      end
   end
   // Sticky: a word offered to a full FIFO is lost
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overflow <= 1'b0;
      end else if (ce && lost_word) begin
         overflow <= 1'b1;
      end
   end
   // ==========================================
   // Pixel buffer
   pix_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .in_valid(push_ff),
      .in_ready(fifo_ready),
      .in_data(word_ff),
      .out_valid(pix_valid),
      .out_ready(pix_ready),
      .out_data(fifo_data)
   );
   assign red = chan_of(fifo_data, RED_LSB);
   assign green = chan_of(fifo_data, GRN_LSB);
   assign blue = chan_of(fifo_data, BLU_LSB);
   assign frame_eye = eye_ff;
   assign glasses_sync = glasses_en && glass_ff;
   // ==========================================
   // Boot status sequence
   wire boot_over = cnt_ff >= 32'(BOOT_CYCLES);
   wire init_over = cnt_ff >= 32'(BOOT_CYCLES + INIT_CYCLES);
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         BOOTING: if (boot_over) nxt_state = INIT_HIGH;
         INIT_HIGH: if (init_over) nxt_state = READY;
         READY: nxt_state = READY;
         default: nxt_state = BOOTING;
      endcase
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= BOOTING;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_ff <= '0;
      end else if (ce && state_ff != READY) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end
   assign link.boot_stat_oe_b = !rst_b || state_ff == BOOTING;
   assign link.boot_stat_o = state_ff != READY;
   assign init_done = state_ff == READY;
endmodule

// ===== core/vid_link_if.sv
`timescale 1ns/1ps
// Purpose: pins between the video source end and the display end
// Assumes: boot status line is tri-state with external pull-up, driven high or low when enabled
// Notes: output enable low means driving
interface vid_link_if;
   import vid_pkg::*;
   logic pix_clk;
   logic [PIX_W-1:0] pixel_data_bus;
   logic vsync;
   logic de;
   logic eye_select;
   logic boot_stat_o;
   logic boot_stat_oe_b;
   wire boot_stat = boot_stat_oe_b ? 1'b1 : boot_stat_o;
   modport dev (input pix_clk, pixel_data_bus, vsync, de, eye_select, boot_stat,
      output boot_stat_o, boot_stat_oe_b);
   modport src (output pix_clk, pixel_data_bus, vsync, de, eye_select, input boot_stat);
endinterface

// ===== core/vid_pkg.sv
// Purpose: shared constants for the video input and boot status link
// Assumes: 40 MHz core clock on both ends
// Notes: boot times are parameters of the display end so a bench can shorten them
package vid_pkg;
   localparam int PIX_W = 24;
   localparam int CHAN_W = 8;
   localparam int RED_LSB = 16;
   localparam int GRN_LSB = 8;
   localparam int BLU_LSB = 0;
   localparam int FIFO_DEPTH = 8;
   localparam int MAX_COLS = 1920;
   localparam int MAX_ROWS = 1080;
   localparam int COL_W = 11;
   localparam int CLK_MHZ = 40;
   localparam int EYE_LEAD_US = 1000;
   localparam int EYE_LEAD_CYC = EYE_LEAD_US * CLK_MHZ;
   localparam int BOOT_MS = 2940;
   localparam int BOOT_VAR_MS = 300;
   localparam int BOOT_CYC = BOOT_MS * 1000 * CLK_MHZ;
   localparam int BOOT_WAIT_CYC = (BOOT_MS + BOOT_VAR_MS) * 1000 * CLK_MHZ;
   localparam int BOOT_DRIVE_CYC = 16;
   localparam int LINK_DIV = 4;
   localparam logic EYE_LEFT = 1'b1;
   localparam logic EYE_RIGHT = 1'b0;
endpackage

// ===== core/vid_src_end.sv
`timescale 1ns/1ps
// Purpose: source end: sends RGB frames, eye tag, waits for boot status
// Assumes: pixel clock made by division of clk
// Notes: one pixel per link clock
module vid_src_end
   import vid_pkg::*;
#(
   parameter int EYE_LEAD = EYE_LEAD_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   vid_link_if.src link,
   input wire logic [CHAN_W-1:0] in_red,
   input wire logic [CHAN_W-1:0] in_green,
   input wire logic [CHAN_W-1:0] in_blue,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic in_sof,
   input wire logic in_eol,
   input wire logic eye_next,
   output logic dev_ready
);
   logic [1:0] bs_ff;
   logic bs_prev_ff, ready_ff;
   logic [1:0] div_ff;
   logic pclk_ff, vs_ff, de_ff, eye_ff, pend_ff;
   logic [PIX_W-1:0] data_ff;
   logic [31:0] lead_ff;
   wire fall_edge = pclk_ff && div_ff == 2'(LINK_DIV/2 - 1);
   // Source may only send after init falling edge
   assign in_ready = ready_ff && fall_edge && !pend_ff;
   assign dev_ready = ready_ff;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bs_ff <= 2'b11;
         bs_prev_ff <= 1'b1;
         ready_ff <= 1'b0;
         div_ff <= '0;
         pclk_ff <= 1'b0;
      end else if (ce) begin
         bs_ff <= {bs_ff[0], link.boot_stat};
         bs_prev_ff <= bs_ff[1];
         if (bs_prev_ff && !bs_ff[1]) ready_ff <= 1'b1;
         div_ff <= (div_ff == 2'(LINK_DIV/2 - 1)) ? 2'b00 : div_ff + 1'b1;
         if (div_ff == 2'(LINK_DIV/2 - 1)) pclk_ff <= !pclk_ff;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vs_ff <= 1'b0;
         de_ff <= 1'b0;
         eye_ff <= EYE_LEFT;
         pend_ff <= 1'b0;
         lead_ff <= '0;
         data_ff <= '0;
      end else if (ce) begin
         if (lead_ff != 0) lead_ff <= lead_ff - 1'b1;
         if (fall_edge) begin
            vs_ff <= 1'b0;
            de_ff <= 1'b0;
         end
         if (ready_ff && in_valid && in_sof && !pend_ff && fall_edge) begin
            eye_ff <= eye_next;
            pend_ff <= 1'b1;
            lead_ff <= 32'(EYE_LEAD);
         end else if (pend_ff && lead_ff == 0 && fall_edge) begin
            vs_ff <= 1'b1;
            pend_ff <= 1'b0;
         end else if (in_ready && in_valid) begin
            data_ff <= {in_red, in_green, in_blue};
            de_ff <= 1'b1;
         end
      end
   end
   assign link.pix_clk = pclk_ff;
   assign link.pixel_data_bus = data_ff;
   assign link.vsync = vs_ff;
   assign link.de = de_ff;
   assign link.eye_select = eye_ff;
endmodule

// ===== tb/vid_link_properties.sv
// Purpose: pin-level checks on the link between source and display ends
// Assumes: one clock domain, synchronous active-low reset
// Notes: instantiated beside the link interface, no bind
`timescale 1ns/1ps
module vid_link_properties
   import vid_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pix_clk,
   input wire logic [PIX_W-1:0] pixel_data_bus,
   input wire logic vsync,
   input wire logic de,
   input wire logic eye_select,
   input wire logic boot_stat_o,
   input wire logic boot_stat_oe_b,
   input wire logic boot_stat
);
   // ==========================================
   // Boot status line
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence undriven_s;
      boot_stat_oe_b[*8];
   endsequence
   sequence drive_high_s;
      (!boot_stat_oe_b && boot_stat_o)[*8];
   endsequence
   AST_RST_TRISTATE: assert property ($rose(rst_b) |-> boot_stat_oe_b && boot_stat)
      else $error("boot line driven at reset release");
   AST_BOOT_UNDRIVEN: assert property ($rose(rst_b) |-> undriven_s)
      else $error("boot line driven during boot");
   AST_INIT_HIGH: assert property ($fell(boot_stat_oe_b) |-> drive_high_s)
      else $error("boot line not driven high first");
   AST_DONE_FALL: assert property ($fell(boot_stat) |-> !boot_stat_oe_b && $past(boot_stat_oe_b, 8) == 1'b0)
      else $error("boot line fell without high drive");
   AST_DONE_HOLD: assert property (!boot_stat |=> !boot_stat)
      else $error("boot line rose after completion");
   // ==========================================
   // Video traffic
   AST_QUIET_BOOT: assert property (boot_stat |-> !vsync && !de)
      else $error("video sent before completion");
   AST_EYE_SETTLED: assert property ($rose(vsync) |-> eye_select == $past(eye_select, 8))
      else $error("eye select changed near vsync");
   AST_PCLK_RATE: assert property ($rose(pix_clk) |=> (!$rose(pix_clk))[*3])
      else $error("pixel clock faster than divider");
   AST_DATA_EDGE: assert property ($changed(pixel_data_bus) |-> $fell(pix_clk))
      else $error("pixel data moved away from clock fall");
endmodule

// ===== tb/video_input_and_boot_status_bench.sv
// Purpose: end-to-end bench joining source end and display end
// Assumes: 40 MHz clk, boot shortened to 100 cycles, eye lead 20
// Notes: display side pixels are collected into a queue
`timescale 1ns/1ps
module video_input_and_boot_status_bench;
   import vid_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, glasses_en = 1'b1, pix_ready = 1'b1, ce = 1'b1;
   logic in_valid = 1'b0, in_sof = 1'b0, eye_next = 1'b1, in_ready, dev_ready;
   logic [23:0] in_px = 24'h0;
   logic [7:0] red, green, blue;
   logic pix_valid, frame_start, frame_eye, glasses_sync, init_done, overflow;
   logic [23:0] got[$];
   int err_total = 0, n_checks = 0, n_frames = 0;
   // ==========================================
   // Design and checker
   vid_link_if i_vid_link_if ();
   vid_src_end #(.EYE_LEAD(20)) i_vid_src_end (.clk(clk), .rst_b(rst_b), .ce(ce), .link(i_vid_link_if),
      .in_red(in_px[23:16]), .in_green(in_px[15:8]), .in_blue(in_px[7:0]), .in_valid(in_valid),
      .in_ready(in_ready), .in_sof(in_sof), .in_eol(1'b0), .eye_next(eye_next), .dev_ready(dev_ready));
   vid_dev_end #(.BOOT_CYCLES(100), .INIT_CYCLES(16)) i_vid_dev_end (.clk(clk), .rst_b(rst_b), .ce(ce),
      .link(i_vid_link_if), .glasses_en(glasses_en), .red(red), .green(green), .blue(blue),
      .pix_valid(pix_valid), .pix_ready(pix_ready), .frame_start(frame_start), .frame_eye(frame_eye),
      .glasses_sync(glasses_sync), .init_done(init_done), .overflow(overflow));
   vid_link_properties i_vid_link_properties (.clk(clk), .rst_b(rst_b), .pix_clk(i_vid_link_if.pix_clk),
      .pixel_data_bus(i_vid_link_if.pixel_data_bus), .vsync(i_vid_link_if.vsync), .de(i_vid_link_if.de),
      .eye_select(i_vid_link_if.eye_select), .boot_stat_o(i_vid_link_if.boot_stat_o),
      .boot_stat_oe_b(i_vid_link_if.boot_stat_oe_b), .boot_stat(i_vid_link_if.boot_stat));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (ce === 1'b1 && pix_valid === 1'b1 && pix_ready === 1'b1) got.push_back({red, green, blue});
      if (frame_start === 1'b1) n_frames++;
   end
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic close_out();
      if (err_total == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic put_px(input logic [23:0] px);
      in_px = px;
      in_valid = 1'b1;
      do @(negedge clk); while (in_ready !== 1'b1);
      @(posedge clk);
      #1;
   endtask
   task automatic push_frame(input logic eye, input int n, input logic [23:0] base);
      got.delete();
      eye_next = eye;
      in_sof = 1'b1;
      put_px(base);
      in_sof = 1'b0;
      for (int i = 0; i < n; i++) put_px(base + 24'h010101 * 24'(i));
      in_valid = 1'b0;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_boot();
      int c;
      c = 0;
      chk(i_vid_link_if.boot_stat, 24'h1);
      chk(init_done, 24'h0);
      chk(dev_ready, 24'h0);
      while (init_done !== 1'b1 && c < 400) begin
         @(posedge clk);
         #1 c++;
      end
      chk(c >= 100, 24'h1);
      chk(c <= 120, 24'h1);
      chk(i_vid_link_if.boot_stat, 24'h0);
      repeat (20) if (dev_ready !== 1'b1) @(posedge clk);
      #1 chk(dev_ready, 24'h1);
   endtask
   task automatic t_frame(input logic eye, input logic [23:0] base);
      int f0;
      f0 = n_frames;
      push_frame(eye, 6, base);
      repeat (300) if (got.size() < 6) @(posedge clk);
      #1 chk(24'(got.size()), 24'h6);
      chk(24'(n_frames - f0), 24'h1);
      foreach (got[i]) chk(got[i], base + 24'h010101 * 24'(i));
      chk(frame_eye, eye);
      chk(glasses_sync, eye);
   endtask
   task automatic t_overflow();
      pix_ready = 1'b0;
      glasses_en = 1'b0;
      push_frame(1'b1, 12, 24'hAA5500);
      repeat (20) @(posedge clk);
      #1 chk(overflow, 24'h1);
      chk(pix_valid, 24'h1);
      chk(frame_eye, 24'h1);
      chk(glasses_sync, 24'h0);
      ce = 1'b0;
      pix_ready = 1'b1;
      repeat (10) @(posedge clk);
      #1 chk(24'(got.size()), 24'h0);
      chk(pix_valid, 24'h1);
      ce = 1'b1;
      repeat (30) @(posedge clk);
      #1 chk(got[0], 24'hAA5500);
      chk(24'(got.size()), 24'(FIFO_DEPTH));
   endtask
   task automatic t_wide();
      push_frame(1'b0, MAX_COLS + 2, 24'h000000);
      repeat (40) @(posedge clk);
      #1 chk(24'(got.size()), 24'(MAX_COLS));
      chk(got[MAX_COLS-1], 24'h010101 * 24'(MAX_COLS - 1));
   endtask
   initial begin
      #2000000;
      err_total++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      t_boot();
      t_frame(1'b1, 24'hF08010);
      t_frame(1'b0, 24'h01FE7F);
      t_overflow();
      t_wide();
      close_out();
   end
endmodule
